// ==== core/timer_wake_read_sync.sv ====
// Timer counters, captures and watchdog with posted / non-posted read paths.
// Assumes the host read and write handshake signals change on the interface clock,
// which this block only samples; every such input passes two flip-flops first.
`timescale 1ns/100ps

module timer_wake_read_sync #(
    parameter int CNT_W    = 32,  // Counter width
    parameter int TIMER_ID = 1    // Instance number of this timer
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Interface clock, sampled as data
    input  wire logic             iface_clk,
    // Host read handshake
    input  wire logic             rd_req,
    input  wire logic [2:0]       rd_sel,
    output logic                  rd_ack,
    output logic [CNT_W-1:0]      rd_data,
    // Host control write handshake
    input  wire logic             wr_req,
    input  wire logic             wr_posted,
    input  wire logic             wr_read_mode,
    // Capture events
    input  wire logic             capt_a_evt,
    input  wire logic             capt_b_evt,
    // Status
    output logic                  iface_awake
);

    // ==========================================================
    // Input synchronisers
    // Stage one is read only by stage two
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync_next;
    logic       iclk_d_reg;   // Delayed interface clock level
    logic       wr_d_reg;     // Delayed write request
    logic       ca_d_reg;     // Delayed capture a
    logic       cb_d_reg;     // Delayed capture b
    always_comb begin
        sync_next = {capt_b_evt, capt_a_evt, wr_read_mode, wr_posted, wr_req,
                     rd_sel[2], rd_sel[1], rd_sel[0]};
    end
    // Plain two flop chain; edge detectors look at stage two only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
        end else begin
            sync1_reg <= sync_next;
            sync2_reg <= sync1_reg;
        end
    end
    logic       iclk_s1_reg;  // Interface clock stage one
    logic       iclk_s2_reg;  // Interface clock stage two
    logic       req_s1_reg;   // Read request stage one
    logic       req_s2_reg;   // Read request stage two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            iclk_s1_reg <= 1'b0;
            iclk_s2_reg <= 1'b0;
            req_s1_reg  <= 1'b0;
            req_s2_reg  <= 1'b0;
            iclk_d_reg  <= 1'b0;
            wr_d_reg    <= 1'b0;
            ca_d_reg    <= 1'b0;
            cb_d_reg    <= 1'b0;
        end else begin
            iclk_s1_reg <= iface_clk;
            iclk_s2_reg <= iclk_s1_reg;
            req_s1_reg  <= rd_req;
            req_s2_reg  <= req_s1_reg;
            iclk_d_reg  <= iclk_s2_reg;
            wr_d_reg    <= sync2_reg[3];
            ca_d_reg    <= sync2_reg[6];
            cb_d_reg    <= sync2_reg[7];
        end
    end

    timer_sync_pkg::rd_cmd_t cmd;  // Synchronised read command
    logic iedge;                   // Interface clock rising edge seen
    logic wr_rise;                 // Control write strobe
    always_comb begin
        cmd.req = req_s2_reg;
        cmd.sel = sync2_reg[2:0];
        iedge   = iclk_s2_reg & ~iclk_d_reg;
        wr_rise = sync2_reg[3] & ~wr_d_reg;
    end
    // ==========================================================
    // Timer core and control register
    logic [CNT_W-1:0] cnt_reg, cnt_next;     // Timer counter
    logic [CNT_W-1:0] ca_reg, ca_next;       // Capture a
    logic [CNT_W-1:0] cb_reg, cb_next;       // Capture b
    logic [CNT_W-1:0] wd_reg, wd_next;       // Watchdog counter
    timer_sync_pkg::sync_ctrl_t ctrl_reg, ctrl_next;
    // Read mode bit hidden on these instances
    localparam logic RM_WO = (TIMER_ID == 1) || (TIMER_ID == 2) || (TIMER_ID == 10);
    always_comb begin
        cnt_next  = cnt_reg + CNT_W'(1);
        wd_next   = wd_reg - CNT_W'(1);
        ca_next   = (sync2_reg[6] & ~ca_d_reg) ? cnt_reg : ca_reg;
        cb_next   = (sync2_reg[7] & ~cb_d_reg) ? cnt_reg : cb_reg;
        ctrl_next = ctrl_reg;
        if (wr_rise) begin
            // Only the timer has this control; the watchdog has none
            ctrl_next.posted    = sync2_reg[4];
            ctrl_next.read_mode = sync2_reg[5];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg            <= '0;
            ca_reg             <= '0;
            cb_reg             <= '0;
            wd_reg             <= CNT_W'(timer_sync_pkg::WDOG_RESET);
            ctrl_reg.posted    <= timer_sync_pkg::POSTED_RESET;
            ctrl_reg.read_mode <= timer_sync_pkg::READ_MODE_RESET;
        end else begin
            cnt_reg  <= cnt_next;
            ca_reg   <= ca_next;
            cb_reg   <= cb_next;
            wd_reg   <= wd_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // ==========================================================
    // Interface side shadows, refreshed on interface edges only.
    // While the interface clock is stopped they freeze, so a posted
    // read just after wake returns a stale copy: the known hazard.
    logic [CNT_W-1:0] sh_cnt_reg, sh_cnt_next;
    logic [CNT_W-1:0] sh_ca_reg, sh_ca_next;
    logic [CNT_W-1:0] sh_cb_reg, sh_cb_next;
    logic [CNT_W-1:0] sh_wd_reg, sh_wd_next;
    logic [7:0]       idle_reg, idle_next;   // Cycles since last edge
    logic             awake_reg, awake_next; // Interface clock running

    always_comb begin
        sh_cnt_next = sh_cnt_reg;
        sh_ca_next  = sh_ca_reg;
        sh_cb_next  = sh_cb_reg;
        sh_wd_next  = sh_wd_reg;
        idle_next   = idle_reg;
        awake_next  = awake_reg;
        if (iedge) begin
            sh_cnt_next = cnt_reg;
            sh_ca_next  = ca_reg;
            sh_cb_next  = cb_reg;
            sh_wd_next  = wd_reg;
            idle_next   = 8'h00;
            awake_next  = 1'b1;
        end else if (idle_reg == timer_sync_pkg::STOP_CYCLES) begin
            awake_next  = 1'b0;
        end else begin
            idle_next   = idle_reg + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sh_cnt_reg <= '0;
            sh_ca_reg  <= '0;
            sh_cb_reg  <= '0;
            sh_wd_reg  <= '0;
            idle_reg   <= 8'h00;
            awake_reg  <= 1'b0;
        end else begin
            sh_cnt_reg <= sh_cnt_next;
            sh_ca_reg  <= sh_ca_next;
            sh_cb_reg  <= sh_cb_next;
            sh_wd_reg  <= sh_wd_next;
            idle_reg   <= idle_next;
            awake_reg  <= awake_next;
        end
    end

    // ==========================================================
    // Read handshake state machine
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,  // Waiting for a request
        ST_SYNC = 3'b010,  // Non-posted read waiting for fresh sync
        ST_DONE = 3'b100   // Answer held until request drops
    } rd_state_t;

    rd_state_t        st_reg, st_next;
    logic [1:0]       edges_reg, edges_next;  // Interface edges waited
    logic [CNT_W-1:0] data_reg, data_next;    // Answer data
    logic             ack_reg, ack_next;      // Answer strobe level
    logic             np_mode;                // Accurate read selected
    logic [CNT_W-1:0] ctrl_word;              // Control readback

    always_comb begin
        np_mode   = ~ctrl_reg.posted & ctrl_reg.read_mode;
        ctrl_word = '0;
        ctrl_word[timer_sync_pkg::POSTED_BIT]    = ctrl_reg.posted;
        // Write-only read mode reads back as zero
        ctrl_word[timer_sync_pkg::READ_MODE_BIT] = ctrl_reg.read_mode & ~RM_WO;
    end

    always_comb begin
        st_next    = st_reg;
        edges_next = edges_reg;
        data_next  = data_reg;
        ack_next   = ack_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (cmd.req) begin
                    unique case (cmd.sel)
                        timer_sync_pkg::SEL_COUNTER,
                        timer_sync_pkg::SEL_CAPT_A,
                        timer_sync_pkg::SEL_CAPT_B: begin
                            if (np_mode) begin
                                // Stall the answer until synchronised
                                edges_next = 2'h0;
                                st_next    = ST_SYNC;
                            end else begin
                                // Posted: shadow copy at once
                                data_next = (cmd.sel == timer_sync_pkg::SEL_COUNTER) ?
                                            sh_cnt_reg :
                                            (cmd.sel == timer_sync_pkg::SEL_CAPT_A) ?
                                            sh_ca_reg : sh_cb_reg;
                                ack_next  = 1'b1;
                                st_next   = ST_DONE;
                            end
                        end
                        timer_sync_pkg::SEL_WATCHDOG: begin
                            // Always posted; host waits out the resync
                            data_next = sh_wd_reg;
                            ack_next  = 1'b1;
                            st_next   = ST_DONE;
                        end
                        timer_sync_pkg::SEL_CTRL: begin
                            data_next = ctrl_word;
                            ack_next  = 1'b1;
                            st_next   = ST_DONE;
                        end
                        default: begin
                            // Unused selector reads zero
                            data_next = '0;
                            ack_next  = 1'b1;
                            st_next   = ST_DONE;
                        end
                    endcase
                end
            end
            ST_SYNC: begin
                if (iedge) begin
                    if (edges_reg == timer_sync_pkg::NP_SYNC_EDGES - 2'h1) begin
                        // Live value taken after full sync
                        data_next = (cmd.sel == timer_sync_pkg::SEL_COUNTER) ? cnt_reg :
                                    (cmd.sel == timer_sync_pkg::SEL_CAPT_A) ? ca_reg :
                                    cb_reg;
                        ack_next  = 1'b1;
                        st_next   = ST_DONE;
                    end else begin
                        edges_next = edges_reg + 2'h1;
                    end
                end
            end
            ST_DONE: begin
                // Four-phase: drop the answer once the request falls
                if (!cmd.req) begin
                    ack_next = 1'b0;
                    st_next  = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg    <= ST_IDLE;
            edges_reg <= 2'h0;
            data_reg  <= '0;
            ack_reg   <= 1'b0;
        end else begin
            st_reg    <= st_next;
            edges_reg <= edges_next;
            data_reg  <= data_next;
            ack_reg   <= ack_next;
        end
    end

    // Outputs straight from flip-flops
    assign rd_ack      = ack_reg;
    assign rd_data     = data_reg;
    assign iface_awake = awake_reg;

endmodule

// ==== core/timer_sync_pkg.sv ====
// Shared constants and carriers for the timer wake read synchroniser.
// Assumes a single system clock; the interface clock is sampled, not used as a clock.
package timer_sync_pkg;

    // ==========================================================
    // Read selectors
    localparam logic [2:0] SEL_COUNTER  = 3'h0;  // General purpose timer counter
    localparam logic [2:0] SEL_CAPT_A   = 3'h1;  // First capture value
    localparam logic [2:0] SEL_CAPT_B   = 3'h2;  // Second capture value
    localparam logic [2:0] SEL_WATCHDOG = 3'h3;  // Watchdog counter
    localparam logic [2:0] SEL_CTRL     = 3'h4;  // Synchronisation control

    // ==========================================================
    // Control field positions and reset values
    localparam int         POSTED_BIT      = 2;
    localparam int         READ_MODE_BIT   = 3;
    localparam logic       POSTED_RESET    = 1'b1;
    localparam logic       READ_MODE_RESET = 1'b0;

    // ==========================================================
    // Timing: interface edges a non-posted read waits for the sync
    localparam logic [1:0] NP_SYNC_EDGES   = 2'h2;
    // Clock cycles with no interface edge before it counts as stopped
    localparam logic [7:0] STOP_CYCLES     = 8'h20;
    // Watchdog counter reset value
    localparam logic [31:0] WDOG_RESET     = 32'hFFFFFFFF;

    // Control register carrier
    typedef struct packed {
        logic read_mode;  // Non-posted read request
        logic posted;     // Posted synchronisation
    } sync_ctrl_t;

    // Read request carrier
    typedef struct packed {
        logic       req;  // Four-phase request level
        logic [2:0] sel;  // Register selector
    } rd_cmd_t;

endpackage

// ==== testbench/timer_wake_read_sync_monitor.sv ====
// Port checker for the timer wake read synchroniser.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/100ps
module timer_wake_read_sync_monitor #(
    parameter int CNT_W    = 32,  // Counter width
    parameter int TIMER_ID = 1    // Instance number
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             rst_n,
    // Host side
    input wire logic             iface_clk,
    input wire logic             rd_req,
    input wire logic [2:0]       rd_sel,
    input wire logic             rd_ack,
    input wire logic [CNT_W-1:0] rd_data,
    input wire logic             wr_req,
    input wire logic             wr_posted,
    input wire logic             wr_read_mode,
    input wire logic             capt_a_evt,
    input wire logic             capt_b_evt,
    input wire logic             iface_awake
);
    // =====================================================
    // Helper state
    logic       np_reg, np_next;     // Non-posted reads requested
    logic       wr_d_reg;            // Last write request level
    logic       ic_d_reg;            // Last interface clock level
    logic [1:0] edg_reg, edg_next;   // Interface rises during a read
    logic [7:0] idle_reg, idle_next; // Cycles since an interface rise
    logic       rise;                // Interface clock rose
    assign rise = iface_clk && !ic_d_reg;
    // Next values; counters saturate so long idles never wrap
    always_comb begin
        np_next = np_reg;
        if (wr_req && !wr_d_reg) begin
            np_next = !wr_posted && wr_read_mode;
        end
        edg_next = edg_reg;
        if (!rd_req) begin
            edg_next = 2'h0;
        end else if (rise && edg_reg != 2'h3) begin
            edg_next = edg_reg + 2'h1;
        end
        idle_next = rise ? 8'h00 : idle_reg + {7'h00, idle_reg != 8'hFF};
    end
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            np_reg   <= 1'b0;
            wr_d_reg <= 1'b0;
            ic_d_reg <= 1'b0;
            edg_reg  <= 2'h0;
            idle_reg <= 8'h00;
        end else begin
            np_reg   <= np_next;
            wr_d_reg <= wr_req;
            ic_d_reg <= iface_clk;
            edg_reg  <= edg_next;
            idle_reg <= idle_next;
        end
    end
    // =====================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_ack_cause: assert property ($rose(rd_ack) |-> $past(rd_req, 3))
        else $error("answer without a held request");
    a_ack_hold: assert property (rd_ack && rd_req |=> rd_ack)
        else $error("answer dropped while request held");
    a_ack_drop: assert property ($fell(rd_req) |-> ##[1:6] !rd_ack)
        else $error("answer not released");
    a_data_stable: assert property (rd_ack ##1 rd_ack |-> $stable(rd_data))
        else $error("read data moved during answer");
    a_np_stall: assert property ($rose(rd_ack) && np_reg && rd_sel < 3'h3 |-> edg_reg >= 2'h2)
        else $error("non-posted answer before two interface edges");
    a_posted_fast: assert property ($rose(rd_req) && !np_reg |-> ##[3:6] rd_ack)
        else $error("posted answer late");
    a_wdog_posted: assert property ($rose(rd_req) && rd_sel == 3'h3 |-> ##[3:6] rd_ack)
        else $error("watchdog read not posted");
    a_mode_hidden: assert property (rd_ack && rd_sel == 3'h4 && TIMER_ID inside {1, 2, 10}
        |-> !rd_data[3])
        else $error("write-only read mode bit visible");
    a_awake_stop: assert property (idle_reg >= 8'h28 |-> !iface_awake)
        else $error("awake flag kept while interface stopped");
    a_awake_wake: assert property (rise |-> ##[1:6] iface_awake)
        else $error("awake flag missed interface edge");
endmodule

bind timer_wake_read_sync timer_wake_read_sync_monitor #(.CNT_W(CNT_W), .TIMER_ID(TIMER_ID))
    mon_u (.clk(clk), .rst_n(rst_n), .iface_clk(iface_clk), .rd_req(rd_req),
    .rd_sel(rd_sel), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
    .wr_posted(wr_posted), .wr_read_mode(wr_read_mode), .capt_a_evt(capt_a_evt),
    .capt_b_evt(capt_b_evt), .iface_awake(iface_awake));

// ==== testbench/host_model.sv ====
// Host model: interface clock plus four-phase read and control write.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
module host_model (
    // Clock and interface clock control
    input  wire logic        clk,
    input  wire logic        run_iclk,
    output logic             iface_clk,
    // Read handshake
    output logic             rd_req,
    output logic [2:0]       rd_sel,
    input  wire logic        rd_ack,
    input  wire logic [31:0] rd_data,
    // Control write
    output logic             wr_req,
    output logic             wr_posted,
    output logic             wr_read_mode
);
    // =====================================================
    // Idle values
    initial begin
        iface_clk    = 1'b0;
        rd_req       = 1'b0;
        rd_sel       = 3'h7;
        wr_req       = 1'b0;
        wr_posted    = 1'b1;
        wr_read_mode = 1'b0;
    end
    // Interface clock, 160 ns, stands low while asleep
    always begin
        wait (run_iclk);
        #80 iface_clk = 1'b1;
        #80 iface_clk = 1'b0;
    end
    // Read: hold until answer, take data at that edge, then release
    task automatic read(input logic [2:0] sel, output logic [31:0] data);
        @(posedge clk);
        #1 rd_sel = sel;
        rd_req = 1'b1;
        do @(posedge clk); while (rd_ack !== 1'b1);
        data = rd_data;
        #1 rd_req = 1'b0;
        rd_sel = ~sel; // Released selector shows no old value
        do @(posedge clk); while (rd_ack !== 1'b0);
    endtask
    // Control write, held long enough for the two-flop sync
    task automatic write(input logic posted, input logic rmode);
        @(posedge clk);
        #1 wr_posted = posted;
        wr_read_mode = rmode;
        wr_req = 1'b1;
        repeat (6) @(posedge clk);
        #1 wr_req = 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // Wake wait before a watchdog read: two interface, one functional
    task automatic wdog_wait;
        repeat (2) @(posedge iface_clk);
        @(posedge clk);
    endtask
endmodule

// ==== testbench/test_timer_wake_read_sync.sv ====
// Bench for the timer wake read synchroniser.
// Assumes host_model as the host and the bound port checker.
`timescale 1ns/100ps
module test_timer_wake_read_sync;
    logic        clk, rst_n, run_iclk, iface_clk;
    logic        rd_req, rd_ack, wr_req, wr_posted, wr_read_mode;
    logic        capt_a_evt, capt_b_evt, iface_awake;
    logic [2:0]  rd_sel;
    logic [31:0] rd_data, d, e, cyc;
    int          bad_count, checks;
    // =====================================================
    // Clock, cycle count since reset, parts
    initial clk = 1'b0;
    always #10 clk = ~clk;
    always @(posedge clk or negedge rst_n) cyc <= rst_n ? cyc + 32'h1 : 32'h0;
    timer_wake_read_sync #(.CNT_W(32), .TIMER_ID(1)) dut_u (.clk(clk), .rst_n(rst_n),
        .iface_clk(iface_clk), .rd_req(rd_req), .rd_sel(rd_sel), .rd_ack(rd_ack),
        .rd_data(rd_data), .wr_req(wr_req), .wr_posted(wr_posted),
        .wr_read_mode(wr_read_mode), .capt_a_evt(capt_a_evt), .capt_b_evt(capt_b_evt),
        .iface_awake(iface_awake));
    host_model host_u (.clk(clk), .run_iclk(run_iclk), .iface_clk(iface_clk),
        .rd_req(rd_req), .rd_sel(rd_sel), .rd_ack(rd_ack), .rd_data(rd_data),
        .wr_req(wr_req), .wr_posted(wr_posted), .wr_read_mode(wr_read_mode));
    // =====================================================
    // Comparisons
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Passes when a is at most 28 above b; slack covers sync delay
    task automatic near(input string what, input logic [31:0] a, input logic [31:0] b);
        checks++;
        if ((a - b <= 32'h1C) !== 1'b1) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, a, b);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // =====================================================
    // Scenarios
    task automatic t_reset;
        chk("reset outputs", 32'h0, {30'h0, rd_ack, iface_awake});
        chk("reset data", 32'h0, rd_data);
        #1 rst_n = 1'b1;
        host_u.read(timer_sync_pkg::SEL_CTRL, d);
        chk("control after reset", 32'h4, d);
        $display("t_reset done");
    endtask
    task automatic t_posted;
        #1 run_iclk = 1'b1;
        repeat (40) @(posedge clk);
        chk("awake while running", 32'h1, {31'h0, iface_awake});
        host_u.read(timer_sync_pkg::SEL_COUNTER, d);
        near("posted counter", cyc + 32'h2, d);
        host_u.read(3'h5, d);
        chk("unmapped read", 32'h0, d);
        $display("t_posted done");
    endtask
    task automatic t_nonposted;
        host_u.write(1'b0, 1'b1);
        host_u.read(timer_sync_pkg::SEL_CTRL, d);
        chk("control read mode hidden", 32'h0, d);
        #1 capt_a_evt = 1'b1;
        repeat (16) @(posedge clk);
        #1 capt_b_evt = 1'b1;
        capt_a_evt = 1'b0;
        run_iclk = 1'b0;
        repeat (60) @(posedge clk);
        chk("awake after stop", 32'h0, {31'h0, iface_awake});
        fork
            host_u.read(timer_sync_pkg::SEL_COUNTER, d);
            begin
                repeat (30) @(posedge clk);
                chk("stalled answer", 32'h2, {30'h0, rd_req, rd_ack});
                #1 run_iclk = 1'b1;
            end
        join
        near("non-posted counter", cyc + 32'h2, d);
        host_u.read(timer_sync_pkg::SEL_CAPT_A, e);
        host_u.read(timer_sync_pkg::SEL_CAPT_B, d);
        chk("capture spacing", 32'h10, d - e);
        $display("t_nonposted done");
    endtask
    task automatic t_wdog;
        #1 run_iclk = 1'b0;
        capt_b_evt = 1'b0;
        repeat (60) @(posedge clk);
        host_u.read(timer_sync_pkg::SEL_WATCHDOG, d);
        #1 run_iclk = 1'b1;
        host_u.wdog_wait;
        host_u.read(timer_sync_pkg::SEL_WATCHDOG, d);
        near("watchdog after wake", d, timer_sync_pkg::WDOG_RESET - cyc - 32'h2);
        $display("t_wdog done");
    endtask
    // =====================================================
    // Main sequence and watchdog
    initial begin
        rst_n = 1'b0;
        run_iclk = 1'b0;
        capt_a_evt = 1'b0;
        capt_b_evt = 1'b0;
        bad_count = 0;
        checks = 0;
        repeat (10) @(posedge clk);
        t_reset;
        t_posted;
        t_nonposted;
        t_wdog;
        end_sim;
    end
    initial begin
        #100us;
        bad_count++;
        end_sim;
    end
endmodule
